//--- core/spcl_pkg.sv
// Purpose: Shared constants of the strap page configuration loader
// Assumes: 40 MHz core clock; three-state straps arrive already digitised as level codes
// Notes: Config word layout, reset values, level codes and loader states
//
// Function
// - Hard mode loads whole config from ROM
// - Hard mode latches six two-state straps, 64 pages
// - Hard mode keeps host on, address low zero
// - Hard mode syncs dividers at power-up, power-down toggle
// - Host may overwrite any config once enabled
// - Clock outputs disabled while in reset
// - Soft mode: nine states, six pages, defaults, two invalid
// - Both page straps floating loads register defaults
// - Soft mode strap 0 is active-low sync
// - Soft mode address strap sets address low bits
// - Soft mode straps 4,5 set margining
// - Soft mode latches page straps, applies EEPROM page
// - Invalid source mutes per channel mute controls
// - Muted differential: positive rail, negative ground
// - Muted single-ended output held low
// - Eight-bit output divider, ratios one to 256
// - Config sets each channel format or disable
// - Config sets status pin clock or status
// - Each page holds readable eight-bit identifier
`default_nettype none

package spcl_pkg;
	// ***********************************************
	// Geometry
	// ***********************************************
	localparam int NUM_CH = 4;          // Output channels
	localparam int CFG_WORDS = 16;      // Config words per page
	localparam logic [3:0] CFG_LAST = 4'hf;
	// ***********************************************
	// Config word offsets
	// ***********************************************
	localparam logic [3:0] CFG_ID = 4'h0;     // Page identifier
	localparam logic [3:0] CFG_DIV0 = 4'h1;   // Divider of channel 0, then 1..3
	localparam logic [3:0] CFG_FMT0 = 4'h5;   // Format of channel 0, then 1..3
	localparam logic [3:0] CFG_MUTE0 = 4'h9;  // Mute controls of channel 0, then 1..3
	localparam logic [3:0] CFG_STAT = 4'hd;   // Status pin setup
	localparam logic [7:0] REG_STATUS = 8'h40; // Loader status readback
	// ***********************************************
	// Field positions and codes
	// ***********************************************
	localparam int MUTE_EN_BIT = 0;
	localparam int MUTE_LVL_LSB = 1;
	localparam int STAT_CLK_BIT = 0;    // 1: status pin is a clock
	localparam int STAT_SLEW_BIT = 1;   // Slow edge when set
	localparam int STAT_DIV_LSB = 2;    // Status clock divider, 6 bits
	localparam logic [2:0] FMT_OFF = 3'h0;   // Channel disabled
	localparam logic [2:0] FMT_CMOS = 3'h4;  // Single-ended; others differential
	// ***********************************************
	// Reset values of config words
	// ***********************************************
	localparam logic [7:0] DEF_ID = 8'h00;
	localparam logic [7:0] DEF_DIV = 8'h03;   // Divide by four
	localparam logic [7:0] DEF_FMT = 8'h01;
	localparam logic [7:0] DEF_MUTE = 8'h07;  // Enable 1, level 3
	localparam logic [7:0] DEF_STAT = 8'h00;
	// ***********************************************
	// Strap level codes and address bits
	// ***********************************************
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;    // Also the floating level
	localparam logic [1:0] LVL_VDD = 2'h2;
	localparam logic [1:0] ADDR_GND = 2'h0;
	localparam logic [1:0] ADDR_MID = 2'h1;
	localparam logic [1:0] ADDR_VDD = 2'h3;
	localparam logic [1:0] ADDR_HARD = 2'h0;
	// ***********************************************
	// Page sources
	// ***********************************************
	localparam logic [1:0] SRC_ROM = 2'h0;
	localparam logic [1:0] SRC_EEPROM = 2'h1;
	localparam logic [1:0] SRC_DEFAULT = 2'h2;
	// ***********************************************
	// Timing
	// ***********************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int SYNC_PULSE_NS = 100;
	localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ***********************************************
	// Loader states
	// ***********************************************
	typedef enum logic [3:0] {
		ST_RESET = 4'h1,
		ST_FETCH = 4'h2,
		ST_SYNC = 4'h4,
		ST_RUN = 4'h8
	} spcl_state_t;
endpackage : spcl_pkg

`default_nettype wire

//--- core/spcl_loader.sv
// Purpose: Strap latch, page load, host overwrite, sync and auto mute of the clock generator
// Assumes: Page memory answers one cycle after page_rd_out; all pins are asynchronous
// Notes: Register port is 8-bit; config words 0x00..0x0f, status at 0x40
`default_nettype none

module spcl_loader (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic config_mode_select_in,       // 1: hard pin mode
	input wire logic power_down_pin_n_in,         // Low holds device in reset
	input wire logic [5:0] strap_bin_in,          // Two-state view of straps 0..5
	input wire logic [1:0] strap1_lvl_in,         // Address strap level code
	input wire logic [1:0] strap2_lvl_in,         // Page strap low
	input wire logic [1:0] strap3_lvl_in,         // Page strap high
	input wire logic [2:0] strap5_lvl_in,         // Eight-level offset_select_a offset
	input wire logic [3:0] source_valid_in,       // Per channel source valid
	input wire logic [7:0] page_data_in,          // Page word, one cycle after read
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic page_rd_out,
	output logic [1:0] page_src_out,
	output logic [5:0] page_sel_out,
	output logic [3:0] page_addr_out,
	output logic host_if_enable_out,
	output logic [1:0] slave_addr_lsb_out,
	output logic div_sync_out,
	output logic offset_select_a_enable_out,
	output logic [2:0] offset_select_a_out,
	output logic [3:0] ch_enable_out,
	output logic [31:0] ch_div_out,
	output logic [11:0] ch_format_out,
	output logic [3:0] mute_pos_rail_out,
	output logic [3:0] mute_neg_gnd_out,
	output logic [3:0] mute_se_low_out,
	output logic status_is_clock_out,
	output logic status_slow_slew_out,
	output logic [5:0] status_div_out
);
	// ***********************************************
	// Functions
	// ***********************************************
	// Reset value of one config word
	function automatic logic [7:0] spcl_default(input logic [3:0] idx);
		logic [7:0] w;
		w = spcl_pkg::DEF_STAT;
		if (idx == spcl_pkg::CFG_ID)
			w = spcl_pkg::DEF_ID;
		else if (idx >= spcl_pkg::CFG_DIV0 && idx < spcl_pkg::CFG_FMT0)
			w = spcl_pkg::DEF_DIV;
		else if (idx >= spcl_pkg::CFG_FMT0 && idx < spcl_pkg::CFG_MUTE0)
			w = spcl_pkg::DEF_FMT;
		else if (idx >= spcl_pkg::CFG_MUTE0 && idx < spcl_pkg::CFG_STAT)
			w = spcl_pkg::DEF_MUTE;
		return w;
	endfunction : spcl_default

	// nine strap states decoded
	// Two page straps to EEPROM page; bit 3 means defaults, bit 4 invalid
	function automatic logic [4:0] spcl_soft_page(input logic [1:0] hi, input logic [1:0] lo);
		logic [4:0] r;
		r = 5'h10;
		if (hi == spcl_pkg::LVL_MID && lo == spcl_pkg::LVL_MID)
			r = 5'h08;
		else if (hi == spcl_pkg::LVL_GND && lo == spcl_pkg::LVL_GND)
			r = 5'h00;
		else if (hi == spcl_pkg::LVL_GND && lo == spcl_pkg::LVL_MID)
			r = 5'h01;
		else if (hi == spcl_pkg::LVL_GND && lo == spcl_pkg::LVL_VDD)
			r = 5'h02;
		else if (hi == spcl_pkg::LVL_MID && lo == spcl_pkg::LVL_GND)
			r = 5'h03;
		else if (hi == spcl_pkg::LVL_MID && lo == spcl_pkg::LVL_VDD)
			r = 5'h04;
		else if (hi == spcl_pkg::LVL_VDD && lo == spcl_pkg::LVL_MID)
			r = 5'h05;
		return r;
	endfunction : spcl_soft_page

	// ***********************************************
	// Pin synchronisers
	// ***********************************************
	localparam int AW = 21;
	logic [AW-1:0] async_w;     // All pin inputs in one bundle
	logic [AW-1:0] meta_r;      // First stage, read only by sync_r
	logic [AW-1:0] sync_r;      // Safe copy
	assign async_w = {source_valid_in, strap5_lvl_in, strap3_lvl_in, strap2_lvl_in, strap1_lvl_in,
		strap_bin_in, power_down_pin_n_in, config_mode_select_in};

	// Two flops on every pin
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= async_w;
			sync_r <= meta_r;
		end
	end

	logic mode_s;               // Synchronised mode select
	logic pdn_n_s;              // Synchronised power-down, low active
	logic [5:0] bin_s;
	logic [3:0] valid_s;
	assign mode_s = sync_r[0];
	assign pdn_n_s = sync_r[1];
	assign bin_s = sync_r[7:2];
	assign valid_s = sync_r[20:17];

	// ***********************************************
	// Loader state
	// ***********************************************
	spcl_pkg::spcl_state_t state_r, state_nxt;
	logic [3:0] idx_r, idx_nxt;           // Word being loaded
	logic pend_r, pend_nxt;               // Page read awaiting data
	logic [2:0] cnt_r, cnt_nxt;           // Sync pulse length
	logic mode_l_r, mode_l_nxt;           // Latched mode
	logic [5:0] bin_l_r, bin_l_nxt;       // Latched two-state straps
	logic [1:0] s1_l_r, s1_l_nxt;         // Latched address strap
	logic [4:0] page_l_r, page_l_nxt;     // Latched soft page decode
	logic [2:0] s5_l_r, s5_l_nxt;         // Latched offset_select_a offset
	logic [7:0] cfg_r [0:15];             // Live configuration
	logic [7:0] cfg_nxt [0:15];
	logic use_def;                        // Page load skipped
	logic run;

	assign run = (state_r == spcl_pkg::ST_RUN);
	assign use_def = !mode_l_r && (page_l_r[3] || page_l_r[4]);

	// Next state of loader, latches and configuration
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		pend_nxt = pend_r;
		cnt_nxt = cnt_r;
		mode_l_nxt = mode_l_r;
		bin_l_nxt = bin_l_r;
		s1_l_nxt = s1_l_r;
		page_l_nxt = page_l_r;
		s5_l_nxt = s5_l_r;
		cfg_nxt = cfg_r;
		case (state_r)
			spcl_pkg::ST_RESET:
			begin
				if (pdn_n_s)
				begin
					mode_l_nxt = mode_s;
					bin_l_nxt = bin_s;
					s1_l_nxt = sync_r[9:8];
					page_l_nxt = spcl_soft_page(sync_r[13:12], sync_r[11:10]);
					s5_l_nxt = sync_r[16:14];
					idx_nxt = '0;
					pend_nxt = 1'b0;
					state_nxt = spcl_pkg::ST_FETCH;
				end
			end
			spcl_pkg::ST_FETCH:
			begin
				if (use_def)
				begin
					cfg_nxt[idx_r] = spcl_default(idx_r);
					idx_nxt = idx_r + 4'h1;
					if (idx_r == spcl_pkg::CFG_LAST)
						state_nxt = spcl_pkg::ST_SYNC;
				end
				else if (!pend_r)
					pend_nxt = 1'b1;
				else
				begin
					cfg_nxt[idx_r] = page_data_in;
					pend_nxt = 1'b0;
					idx_nxt = idx_r + 4'h1;
					if (idx_r == spcl_pkg::CFG_LAST)
						state_nxt = spcl_pkg::ST_SYNC;
				end
				cnt_nxt = '0;
			end
			spcl_pkg::ST_SYNC:
			begin
				// Hold the divider sync for its full width
				cnt_nxt = cnt_r + 3'h1;
				if (cnt_r == 3'(spcl_pkg::SYNC_PULSE_CYC - 1))
					state_nxt = spcl_pkg::ST_RUN;
			end
			spcl_pkg::ST_RUN:
			begin
				if (reg_wr_in && reg_addr_in[7:4] == 4'h0)
					cfg_nxt[reg_addr_in[3:0]] = reg_wdata_in;
			end
			default:
				state_nxt = spcl_pkg::ST_RESET;
		endcase
		if (!pdn_n_s)
			state_nxt = spcl_pkg::ST_RESET;
	end

	// Register loader state
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= spcl_pkg::ST_RESET;
			idx_r <= '0;
			pend_r <= 1'b0;
			cnt_r <= '0;
			mode_l_r <= 1'b0;
			bin_l_r <= '0;
			s1_l_r <= '0;
			page_l_r <= '0;
			s5_l_r <= '0;
			for (int i = 0; i < spcl_pkg::CFG_WORDS; i++)
				cfg_r[i] <= spcl_default(4'(i));
		end
		else
		begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			pend_r <= pend_nxt;
			cnt_r <= cnt_nxt;
			mode_l_r <= mode_l_nxt;
			bin_l_r <= bin_l_nxt;
			s1_l_r <= s1_l_nxt;
			page_l_r <= page_l_nxt;
			s5_l_r <= s5_l_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// ***********************************************
	// Page fetch port
	// ***********************************************
	// Read strobe is a one-cycle pulse with no acknowledge, decoded from flops
	assign page_rd_out = (state_r == spcl_pkg::ST_FETCH) && !use_def && !pend_r;
	assign page_addr_out = idx_r;
	assign page_src_out = mode_l_r ? spcl_pkg::SRC_ROM : (use_def ? spcl_pkg::SRC_DEFAULT : spcl_pkg::SRC_EEPROM);
	// six straps name one of 64
	assign page_sel_out = mode_l_r ? bin_l_r : {3'h0, page_l_r[2:0]};

	// ***********************************************
	// Outputs held in flops
	// ***********************************************
	logic [7:0] rdata_r, rdata_nxt;
	logic sync_o_r, sync_o_nxt;
	logic [1:0] addr_r, addr_nxt;
	logic [3:0] en_r, en_nxt;
	logic [3:0] pos_r, pos_nxt;
	logic [3:0] neg_r, neg_nxt;
	logic [3:0] se_r, se_nxt;
	logic [7:0] stat_w;

	// Status byte: run, mode, source, invalid, sync pin
	assign stat_w = {2'h0, sync_r[2], page_l_r[4] && !mode_l_r, page_src_out, mode_l_r, run};

	// Next values of the output flops
	always_comb
	begin
		rdata_nxt = '0;
		// Unmapped addresses read zero
		if (reg_rd_in && reg_addr_in[7:4] == 4'h0)
			rdata_nxt = cfg_r[reg_addr_in[3:0]];
		else if (reg_rd_in && reg_addr_in == spcl_pkg::REG_STATUS)
			rdata_nxt = stat_w;
		// sync after power-up in hard mode
		sync_o_nxt = (state_r == spcl_pkg::ST_SYNC) && mode_l_r;
		// strap 0 low syncs in soft mode
		if (run && !mode_l_r && !bin_s[0])
			sync_o_nxt = 1'b1;
		addr_nxt = spcl_pkg::ADDR_HARD;
		if (!mode_l_r && s1_l_r == spcl_pkg::LVL_MID)
			addr_nxt = spcl_pkg::ADDR_MID;
		else if (!mode_l_r && s1_l_r == spcl_pkg::LVL_VDD)
			addr_nxt = spcl_pkg::ADDR_VDD;
		else if (!mode_l_r)
			addr_nxt = spcl_pkg::ADDR_GND;
		for (int c = 0; c < spcl_pkg::NUM_CH; c++)
		begin
			en_nxt[c] = run && cfg_r[spcl_pkg::CFG_FMT0 + 4'(c)][2:0] != spcl_pkg::FMT_OFF;
			pos_nxt[c] = en_nxt[c] && !valid_s[c] && cfg_r[spcl_pkg::CFG_MUTE0 + 4'(c)][spcl_pkg::MUTE_EN_BIT];
			se_nxt[c] = pos_nxt[c] && cfg_r[spcl_pkg::CFG_FMT0 + 4'(c)][2:0] == spcl_pkg::FMT_CMOS;
			pos_nxt[c] = pos_nxt[c] && !se_nxt[c];
			neg_nxt[c] = pos_nxt[c];
		end
	end

	// Register outputs
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rdata_r <= '0;
			sync_o_r <= 1'b0;
			addr_r <= '0;
			en_r <= '0;
			pos_r <= '0;
			neg_r <= '0;
			se_r <= '0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			sync_o_r <= sync_o_nxt;
			addr_r <= addr_nxt;
			en_r <= en_nxt;
			pos_r <= pos_nxt;
			neg_r <= neg_nxt;
			se_r <= se_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;
	assign div_sync_out = sync_o_r;
	assign slave_addr_lsb_out = addr_r;
	assign ch_enable_out = en_r;
	assign mute_pos_rail_out = pos_r;
	assign mute_neg_gnd_out = neg_r;
	assign mute_se_low_out = se_r;
	assign host_if_enable_out = run;
	assign offset_select_a_enable_out = !mode_l_r && bin_l_r[4];
	assign offset_select_a_out = mode_l_r ? 3'h0 : s5_l_r;
	assign status_is_clock_out = cfg_r[spcl_pkg::CFG_STAT][spcl_pkg::STAT_CLK_BIT];
	assign status_slow_slew_out = cfg_r[spcl_pkg::CFG_STAT][spcl_pkg::STAT_SLEW_BIT];
	assign status_div_out = cfg_r[spcl_pkg::CFG_STAT][7:spcl_pkg::STAT_DIV_LSB];

	// Per channel divider and format views
	genvar g;
	generate
		for (g = 0; g < spcl_pkg::NUM_CH; g++)
		begin : g_ch
			assign ch_div_out[8*g +: 8] = cfg_r[spcl_pkg::CFG_DIV0 + 4'(g)];
			assign ch_format_out[3*g +: 3] = cfg_r[spcl_pkg::CFG_FMT0 + 4'(g)][2:0];
		end
	endgenerate

	// ***********************************************
	// Assertions
	// ***********************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Hard mode load finishing and handing over to the sync pulse
	sequence s_enter_sync;
		(state_r == spcl_pkg::ST_FETCH && mode_l_r) ##1 (state_r == spcl_pkg::ST_SYNC);
	endsequence

	AST_HARD_ROM: assert property (page_rd_out && mode_l_r |-> page_src_out == spcl_pkg::SRC_ROM)
		else $error("hard mode page not from ROM");
	AST_HARD_SEL: assert property (page_rd_out && mode_l_r |-> page_sel_out == bin_l_r)
		else $error("hard page select differs from latched straps");
	// A power-down seen while running leaves the run state on the next edge
	AST_HARD_ADDR: assert property (run && mode_l_r && pdn_n_s
		|=> slave_addr_lsb_out == 2'h0 && host_if_enable_out)
		else $error("hard mode address or host enable wrong");
	AST_SYNC_PULSE: assert property (s_enter_sync |=> div_sync_out [*4])
		else $error("hard mode sync pulse too short");
	AST_HOST_WR: assert property (run && reg_wr_in && reg_addr_in == 8'h01
		|=> ch_div_out[7:0] == $past(reg_wdata_in))
		else $error("host write not applied");
	AST_RESET_OFF: assert property (!run |=> ch_enable_out == 4'h0)
		else $error("outputs enabled outside run");
	AST_DEFAULTS: assert property (!mode_l_r && page_l_r == 5'h08 && state_r == spcl_pkg::ST_FETCH
		|-> !page_rd_out)
		else $error("defaults mode fetched a page");
	AST_SOFT_SYNC: assert property (run && $past(run) && !mode_l_r && !bin_s[0] |=> div_sync_out)
		else $error("soft sync input ignored");
	AST_SOFT_ADDR: assert property (run && !mode_l_r && s1_l_r == spcl_pkg::LVL_VDD
		|=> slave_addr_lsb_out == 2'h3)
		else $error("soft address bits wrong");
	AST_MUTE_SE: assert property (en_nxt[0] && !valid_s[0] && cfg_r[9][0] && ch_format_out[2:0] == 3'h4
		|=> mute_se_low_out[0] && !mute_pos_rail_out[0])
		else $error("single-ended mute not low");
	AST_HOLD: assert property (run && $past(run) |-> $stable(bin_l_r) && $stable(page_l_r))
		else $error("latched straps changed while running");
endmodule : spcl_loader

`default_nettype wire

//--- testbench/spcl_page_mem.sv
// Purpose: Behavioural page memory behind the loader page port
// Assumes: Answer on the edge after a read strobe
// Notes: Each word is the page select low nibble joined to the word index
`default_nettype none

module spcl_page_mem (
	input wire logic clk_in,
	input wire logic rd_in,
	input wire logic [5:0] sel_in,
	input wire logic [3:0] addr_in,
	output logic [7:0] data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial data_out = 8'h5a;
	// selected page word
	// Between reads the bus toggles, so a stale word is never mistaken for data
	always @(posedge clk_in)
	begin
		if (rd_in)
			data_out <= {sel_in[3:0], addr_in};
		else
			data_out <= ~data_out;
	end
endmodule : spcl_page_mem

`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: Self-checking bench of the strap page loader
// Assumes: Page memory model answers every page read
// Notes: Straps are driven as the board would, reloads by power-down cycles
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ***********************************************
	// Signals
	// ***********************************************
	logic core_clk_in, rst_n_in, config_mode_select_in, power_down_pin_n_in, reg_wr_in, reg_rd_in;
	logic [5:0] strap_bin_in, page_sel_out, status_div_out;
	logic [1:0] strap1_lvl_in, strap2_lvl_in, strap3_lvl_in, page_src_out, slave_addr_lsb_out;
	logic [2:0] strap5_lvl_in, offset_select_a_out;
	logic [3:0] source_valid_in, page_addr_out, ch_enable_out, mute_pos_rail_out, mute_neg_gnd_out, mute_se_low_out;
	logic [7:0] page_data_in, reg_addr_in, reg_wdata_in, reg_rdata_out, rd;
	logic page_rd_out, host_if_enable_out, div_sync_out, offset_select_a_enable_out, status_is_clock_out, status_slow_slew_out;
	logic [31:0] ch_div_out;
	logic [11:0] ch_format_out;
	int n_errors, comparisons, sync_cycles;
	// Soft page per strap combination; 7 marks register defaults
	localparam logic [2:0] PG [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h7, 3'h5, 3'h7};

	spcl_loader spcl_loader_i (.core_clk_in, .rst_n_in, .config_mode_select_in, .power_down_pin_n_in,
		.strap_bin_in, .strap1_lvl_in, .strap2_lvl_in, .strap3_lvl_in, .strap5_lvl_in, .source_valid_in,
		.page_data_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .page_rd_out,
		.page_src_out, .page_sel_out, .page_addr_out, .host_if_enable_out, .slave_addr_lsb_out, .div_sync_out,
		.offset_select_a_enable_out, .offset_select_a_out, .ch_enable_out, .ch_div_out, .ch_format_out,
		.mute_pos_rail_out, .mute_neg_gnd_out, .mute_se_low_out, .status_is_clock_out,
		.status_slow_slew_out, .status_div_out);
	spcl_page_mem spcl_page_mem_i (.clk_in(core_clk_in), .rd_in(page_rd_out), .sel_in(page_sel_out),
		.addr_in(page_addr_out), .data_out(page_data_in));

	// 40 MHz clock
	initial
	begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	// ***********************************************
	// Shared tasks
	// ***********************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : tick

	// Bounded wait for the host interface; counts sync cycles on the way
	task automatic wait_run();
		sync_cycles = 0;
		for (int k = 0; k < 400 && host_if_enable_out !== 1'b1; k++)
		begin
			tick(1);
			sync_cycles += (div_sync_out === 1'b1);
		end
		// A load that never finishes counts as a mismatch and ends the run
		if (host_if_enable_out !== 1'b1)
		begin
			check("host_if_enable_out", host_if_enable_out, 1'b1);
			report_and_stop();
		end
		// The pulse may trail the state change by a cycle
		for (int k = 0; k < 3; k++)
		begin
			tick(1);
			sync_cycles += (div_sync_out === 1'b1);
		end
	endtask : wait_run

	// never cycled mid programming; the model has no programming step
	task automatic power_cycle();
		@(posedge core_clk_in);
		power_down_pin_n_in <= 1'b0;
		tick(6);
		check("ch_enable_out in power-down", ch_enable_out, 4'h0);
		@(posedge core_clk_in);
		power_down_pin_n_in <= 1'b1;
		wait_run();
	endtask : power_cycle

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask : reg_read
	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_hard();
		config_mode_select_in <= 1'b1;
		strap_bin_in <= 6'h2a;
		power_cycle();
		check("sync cycles", sync_cycles, 4);
		check("page_src_out", page_src_out, spcl_pkg::SRC_ROM);
		check("page_sel_out", page_sel_out, 6'h2a);
		check("slave_addr_lsb_out", slave_addr_lsb_out, spcl_pkg::ADDR_HARD);
		check("ch_div_out", ch_div_out, 32'ha4a3a2a1);
		check("ch_format_out", ch_format_out, {3'h0, 3'h7, 3'h6, 3'h5});
		check("ch_enable_out", ch_enable_out, 4'h7);
		check("status pin", {status_is_clock_out, status_slow_slew_out, status_div_out}, 8'hab);
		reg_read({4'h0, spcl_pkg::CFG_ID}, rd);
		check("page id", rd, 8'ha0);
		@(posedge core_clk_in);
		strap_bin_in <= 6'h15;
		tick(8);
		check("page_sel_out held", page_sel_out, 6'h2a);
		$display("hard pin test done");
	endtask : t_hard

	task automatic t_mute();
		@(posedge core_clk_in);
		source_valid_in <= 4'h0;
		tick(6);
		check("mute_pos_rail_out", mute_pos_rail_out, 4'h5);
		check("mute_neg_gnd_out", mute_neg_gnd_out, 4'h5);
		check("mute_se_low_out", mute_se_low_out, 4'h0);
		reg_write({4'h0, spcl_pkg::CFG_FMT0}, {5'h0, spcl_pkg::FMT_CMOS});
		tick(4);
		check("mute_se_low_out", mute_se_low_out, 4'h1);
		check("mute_pos_rail_out", mute_pos_rail_out, 4'h4);
		reg_read({4'h0, spcl_pkg::CFG_FMT0}, rd);
		check("format readback", rd, 8'h04);
		// Largest divider code, ratio 256
		reg_write({4'h0, spcl_pkg::CFG_DIV0}, 8'hff);
		tick(1);
		check("ch_div_out written", ch_div_out[7:0], 8'hff);
		reg_write(8'h80, 8'hff);
		reg_read(8'h80, rd);
		check("unmapped readback", rd, 8'h00);
		@(posedge core_clk_in);
		source_valid_in <= 4'hf;
		tick(6);
		check("mute_pos_rail_out valid", mute_pos_rail_out, 4'h0);
		$display("mute test done");
	endtask : t_mute

	// Every page strap combination, with address and offset_select_a straps swept beside it
	task automatic t_soft();
		logic [3:0] n;
		for (int i = 0; i < 9; i++)
		begin
			@(posedge core_clk_in);
			config_mode_select_in <= 1'b0;
			strap3_lvl_in <= 2'(i / 3);
			strap2_lvl_in <= 2'(i % 3);
			strap1_lvl_in <= 2'(i % 3);
			strap_bin_in <= {1'b0, i[0], 4'h1};
			strap5_lvl_in <= i[2:0];
			power_cycle();
			n = {1'b0, PG[i]};
			if (PG[i] == 3'h7)
			begin
				check("page_src_out", page_src_out, spcl_pkg::SRC_DEFAULT);
				check("ch_div_out", ch_div_out, {4{spcl_pkg::DEF_DIV}});
				// Status: sync pin high, invalid flag, defaults source, soft, running
				reg_read(spcl_pkg::REG_STATUS, rd);
				check("status invalid flag", rd, {3'h1, 1'(i != 4), 4'h9});
			end
			else
			begin
				check("page_src_out", page_src_out, spcl_pkg::SRC_EEPROM);
				check("page_sel_out", page_sel_out, {3'h0, PG[i]});
				check("ch_div_out", ch_div_out, {n, 4'h4, n, 4'h3, n, 4'h2, n, 4'h1});
			end
			check("slave_addr_lsb_out", slave_addr_lsb_out, (i % 3 == 0) ? spcl_pkg::ADDR_GND :
				(i % 3 == 1) ? spcl_pkg::ADDR_MID : spcl_pkg::ADDR_VDD);
			check("offset_select_a_enable_out", offset_select_a_enable_out, i[0]);
			check("offset_select_a_out", offset_select_a_out, i[2:0]);
		end
		@(posedge core_clk_in);
		source_valid_in <= 4'h0;
		tick(6);
		check("default mute", mute_pos_rail_out, 4'hf);
		@(posedge core_clk_in);
		source_valid_in <= 4'hf;
		strap_bin_in[0] <= 1'b0;
		tick(6);
		check("div_sync_out low strap", div_sync_out, 1'b1);
		@(posedge core_clk_in);
		strap_bin_in[0] <= 1'b1;
		tick(6);
		check("div_sync_out high strap", div_sync_out, 1'b0);
		$display("soft pin test done");
	endtask : t_soft

	initial
	begin
		n_errors = 0;
		comparisons = 0;
		rst_n_in = 1'b0;
		power_down_pin_n_in = 1'b1;
		config_mode_select_in = 1'b0;
		strap_bin_in = 6'h01;
		{strap1_lvl_in, strap2_lvl_in, strap3_lvl_in} = 6'h15;
		strap5_lvl_in = 3'h0;
		source_valid_in = 4'hf;
		{reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = 18'h0;
		tick(10);
		check("ch_enable_out in reset", ch_enable_out, 4'h0);
		@(posedge core_clk_in);
		rst_n_in <= 1'b1;
		t_hard();
		t_mute();
		t_soft();
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
